// *** hdl/pmam_defines.svh ***
// pmam_defines.svh: register offsets, field positions, reset values, timing
// assumes a 32-bit AHB-Lite bus and a 10 MHz hclk
`ifndef PMAM_DEFINES_SVH
`define PMAM_DEFINES_SVH

`define PMAM_CLK_MHZ      10
// register byte offsets
`define PMAM_A_CFG        8'h00
`define PMAM_A_ADC        8'h04
`define PMAM_A_DIAG       8'h08
`define PMAM_A_THR0       8'h0c
`define PMAM_A_RES0       8'h24
`define PMAM_A_LAST       8'h30
// config register
`define PMAM_CFG_RST      0
// conversion configuration fields
`define PMAM_ADC_MODE     1:0
`define PMAM_ADC_EN       4:2
`define PMAM_ADC_CTS      7:5
`define PMAM_ADC_CTB      10:8
`define PMAM_ADC_CTT      13:11
`define PMAM_ADC_AVG      16:14
`define PMAM_ADC_W        17
`define PMAM_ADC_RST      17'h029be
// diagnostic status register fields
`define PMAM_D_OVF        0
`define PMAM_D_TRIM       1
`define PMAM_D_CNV        2
`define PMAM_D_LIM        8:3
`define PMAM_D_CFG        15:12
`define PMAM_DCFG_RST     4'h0
// threshold reset values: shunt low, shunt high, bus high, bus low, heat, power
`define PMAM_THR_SUL      16'h8000
`define PMAM_THR_SOL      16'h7fff
`define PMAM_THR_BOL      16'h7fff
`define PMAM_THR_BUL      16'h0000
`define PMAM_THR_TMP      16'hffff
`define PMAM_THR_PWR      16'h7fff
// conversion times in microseconds, per 3-bit code
`define PMAM_CT0_US       50
`define PMAM_CT1_US       84
`define PMAM_CT2_US       150
`define PMAM_CT3_US       280
`define PMAM_CT4_US       540
`define PMAM_CT5_US       1052
`define PMAM_CT6_US       2074
`define PMAM_CT7_US       4120

`endif

// *** hdl/pmam_pkg.sv ***
// pmam_pkg: types of the power monitor alert and mode logic
// assumes pmam_defines.svh is on the include path
package pmam_pkg;

   // sequencer states, gray along shutdown -> convert -> finish
   typedef enum logic [1:0] {
      PMAM_SD   = 2'b00,
      PMAM_CONV = 2'b01,
      PMAM_FIN  = 2'b11
   } pmam_state_t;

   typedef enum logic [1:0] {
      PMAM_M_SD   = 2'b00,
      PMAM_M_TRIG = 2'b01,
      PMAM_M_CONT = 2'b10
   } pmam_mode_t;

   // samples presented by the front end and calculation engine
   typedef struct packed {
      logic signed [15:0] power;
      logic signed [15:0] temp;
      logic signed [15:0] bus;
      logic signed [15:0] shunt;
   } pmam_sample_t;

   // limit flags, bit order as in the status register
   typedef struct packed {
      logic shunt_over_flag;
      logic shunt_under_flag;
      logic bus_over_limit_flag;
      logic bus_under_limit_flag;
      logic overheat_flag;
      logic power_over_limit_flag;
   } pmam_flags_t;

endpackage

// *** hdl/pmam_top.sv ***
// pmam_top: alert, limit compare, averaging and mode control of a power monitor
// assumes one AHB-Lite master on hclk; samples arrive on hclk, trim_ok from a pin
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pmam_defines.svh"

module pmam_top #(
   parameter int unsigned CYC_PER_US = `PMAM_CLK_MHZ
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  ce,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire pmam_pkg::pmam_sample_t smp,
   input  wire logic                  arith_ovf,
   input  wire logic                  trim_ok_pin,
   output logic                       alert_o,
   output logic                       alert_oe_n
);
   import pmam_pkg::*;

   logic [`PMAM_ADC_W-1:0] adc_cfg;
   logic [3:0]             dcfg;
   logic [15:0]            thr [6];
   logic [15:0]            res [4];
   logic signed [25:0]     acc [4];
   pmam_flags_t            flags;
   logic                   conv_done_flag;
   logic                   arithmetic_overflow_flag;
   logic                   trim_meta;
   logic                   trim_memory_ok_flag;
   logic                   wr_pend;
   logic [7:0]             wr_adr;
   logic                   rd_pend;
   logic [7:0]             rd_adr;
   logic [31:0]            rd_mux;
   pmam_state_t            st;
   logic [1:0]             ch;
   logic [31:0]            tmr;
   logic [9:0]             avg_n;

   // config fields
   wire alert_hold_enable      = dcfg[3];
   wire conv_done_alert_enable = dcfg[2];
   wire averaged_compare_enable = dcfg[1];
   wire alert_polarity_select  = dcfg[0];
   wire [2:0] en   = adc_cfg[`PMAM_ADC_EN];
   wire [2:0] avgc = adc_cfg[`PMAM_ADC_AVG];
   wire [1:0] mode = adc_cfg[`PMAM_ADC_MODE];

   function automatic logic [31:0] ct_cyc(input logic [2:0] c);
      logic [31:0] t;
      t = 32'(`PMAM_CT0_US);
      unique case (c)
         3'h0: t = 32'(`PMAM_CT0_US);
         3'h1: t = 32'(`PMAM_CT1_US);
         3'h2: t = 32'(`PMAM_CT2_US);
         3'h3: t = 32'(`PMAM_CT3_US);
         3'h4: t = 32'(`PMAM_CT4_US);
         3'h5: t = 32'(`PMAM_CT5_US);
         3'h6: t = 32'(`PMAM_CT6_US);
         3'h7: t = 32'(`PMAM_CT7_US);
      endcase
      return t * CYC_PER_US;
   endfunction

   // conversion time of channel c under configuration a
   function automatic logic [31:0] ch_ct(input logic [`PMAM_ADC_W-1:0] a,
                                        input logic [1:0] c);
      logic [2:0] k;
      k = a[`PMAM_ADC_CTT];
      if (c == 2'd0) k = a[`PMAM_ADC_CTS];
      else if (c == 2'd1) k = a[`PMAM_ADC_CTB];
      return ct_cyc(k);
   endfunction

   // first enabled channel at or after s, 3 when none
   function automatic logic [1:0] nxt(input logic [2:0] e, input logic [2:0] s);
      logic [1:0] r;
      r = 2'd3;
      for (int i = 2; i >= 0; i--) begin
         if (e[i] && 3'(i) >= s) r = 2'(i);
      end
      return r;
   endfunction

   function automatic logic [3:0] ash(input logic [2:0] c);
      logic [3:0] s;
      s = 4'd0;
      unique case (c)
         3'h0: s = 4'd0;
         3'h1: s = 4'd2;
         3'h2: s = 4'd4;
         3'h3: s = 4'd6;
         3'h4: s = 4'd7;
         3'h5: s = 4'd8;
         3'h6: s = 4'd9;
         3'h7: s = 4'd10;
      endcase
      return s;
   endfunction

   // flags owned by channel c (3 is power)
   function automatic pmam_flags_t chm(input logic [1:0] c);
      pmam_flags_t m;
      m = '0;
      unique case (c)
         2'd0: m = 6'b110000;
         2'd1: m = 6'b001100;
         2'd2: m = 6'b000010;
         2'd3: m = 6'b000001;
      endcase
      return m;
   endfunction

   // out-of-range result of channel c for value v
   function automatic pmam_flags_t lim(input logic [1:0] c,
                                      input logic signed [15:0] v);
      pmam_flags_t f;
      f = '0;
      unique case (c)
         2'd0: begin
            f.shunt_over_flag  = v > $signed(thr[1]);
            f.shunt_under_flag = v < $signed(thr[0]);
         end
         2'd1: begin
            f.bus_over_limit_flag  = v > $signed(thr[2]);
            f.bus_under_limit_flag = v < $signed(thr[3]);
         end
         2'd2: f.overheat_flag = v > $signed(thr[4]);
         2'd3: f.power_over_limit_flag = v > $signed(thr[5]);
      endcase
      return f;
   endfunction

   function automatic logic signed [15:0] pick(input logic [1:0] c);
      logic signed [15:0] v;
      v = smp.temp;
      if (c == 2'd0) v = smp.shunt;
      else if (c == 2'd1) v = smp.bus;
      return v;
   endfunction

   // bus handshake
   wire take   = hsel & hready & htrans[1] & ce;
   wire we     = wr_pend & ce;
   wire srst   = we && wr_adr == `PMAM_A_CFG && hwdata[`PMAM_CFG_RST];
   wire mode_wr = we && wr_adr == `PMAM_A_ADC;
   wire diag_rd = rd_pend & ce && rd_adr == `PMAM_A_DIAG;
   wire [`PMAM_ADC_W-1:0] nadc = hwdata[`PMAM_ADC_W-1:0];

   // sequencer events
   wire conv_end = st == PMAM_CONV && tmr == 32'd1;
   wire [1:0] nch = nxt(en, 3'(ch) + 3'd1);
   wire last_rnd = avg_n == 10'((11'd1 << ash(avgc)) - 11'd1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_adr    <= 8'h00;
         rd_pend   <= 1'b0;
         rd_adr    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0;
      end else if (ce) begin
         wr_pend <= take & hwrite;
         rd_pend <= take & ~hwrite;
         if (take) begin
            wr_adr <= haddr[7:0];
            rd_adr <= haddr[7:0];
         end
         // one wait state on reads so a preceding write is visible
         if (take & ~hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend) begin
            hreadyout <= 1'b1;
            hrdata    <= rd_mux;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      if (rd_adr == `PMAM_A_ADC) begin
         rd_mux[`PMAM_ADC_W-1:0] = adc_cfg;
      end else if (rd_adr == `PMAM_A_DIAG) begin
         rd_mux[`PMAM_D_OVF]  = arithmetic_overflow_flag;
         rd_mux[`PMAM_D_TRIM] = trim_memory_ok_flag;
         rd_mux[`PMAM_D_CNV]  = conv_done_flag;
         rd_mux[`PMAM_D_LIM]  = flags;
         rd_mux[`PMAM_D_CFG]  = dcfg;
      end else if (rd_adr >= `PMAM_A_THR0 && rd_adr < `PMAM_A_RES0) begin
         rd_mux[15:0] = thr[3'((rd_adr - `PMAM_A_THR0) >> 2)];
      end else if (rd_adr >= `PMAM_A_RES0 && rd_adr <= `PMAM_A_LAST) begin
         rd_mux[15:0] = res[2'((rd_adr - `PMAM_A_RES0) >> 2)];
      end
   end

   // software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         adc_cfg <= `PMAM_ADC_RST;
         dcfg    <= `PMAM_DCFG_RST;
         thr[0]  <= `PMAM_THR_SUL;
         thr[1]  <= `PMAM_THR_SOL;
         thr[2]  <= `PMAM_THR_BOL;
         thr[3]  <= `PMAM_THR_BUL;
         thr[4]  <= `PMAM_THR_TMP;
         thr[5]  <= `PMAM_THR_PWR;
      end else if (srst) begin
         adc_cfg <= `PMAM_ADC_RST;
         dcfg    <= `PMAM_DCFG_RST;
         thr[0]  <= `PMAM_THR_SUL;
         thr[1]  <= `PMAM_THR_SOL;
         thr[2]  <= `PMAM_THR_BOL;
         thr[3]  <= `PMAM_THR_BUL;
         thr[4]  <= `PMAM_THR_TMP;
         thr[5]  <= `PMAM_THR_PWR;
      end else if (we) begin
         if (mode_wr) adc_cfg <= nadc;
         if (wr_adr == `PMAM_A_DIAG) dcfg <= hwdata[`PMAM_D_CFG];
         if (wr_adr >= `PMAM_A_THR0 && wr_adr < `PMAM_A_RES0) begin
            thr[3'((wr_adr - `PMAM_A_THR0) >> 2)] <= hwdata[15:0];
         end
      end
   end

   // conversion sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st    <= PMAM_SD;
         ch    <= 2'd0;
         tmr   <= 32'd0;
         avg_n <= 10'd0;
      end else if (ce) begin
         avg_n <= (mode_wr || srst || st == PMAM_FIN) ? 10'd0 : avg_n;
         if (srst) begin
            // same sequencer state as power-on, so the default mode restarts
            st  <= PMAM_SD;
            ch  <= 2'd0;
            tmr <= 32'd0;
         end else if (mode_wr) begin
            // abort and restart, or go idle in shutdown mode or when nothing is enabled
            if (nadc[`PMAM_ADC_MODE] != PMAM_M_SD && nxt(nadc[`PMAM_ADC_EN], 3'd0) != 2'd3)
            begin
               st  <= PMAM_CONV;
               ch  <= nxt(nadc[`PMAM_ADC_EN], 3'd0);
               tmr <= ch_ct(nadc, nxt(nadc[`PMAM_ADC_EN], 3'd0));
            end else begin
               st <= PMAM_SD;
            end
         end else begin
            unique case (st)
               PMAM_SD: begin
                  // power-on default of continuous mode starts here
                  if (mode == PMAM_M_CONT && nxt(en, 3'd0) != 2'd3 && tmr == 32'd0) begin
                     st  <= PMAM_CONV;
                     ch  <= nxt(en, 3'd0);
                     tmr <= ch_ct(adc_cfg, nxt(en, 3'd0));
                  end
               end
               PMAM_CONV: begin
                  if (!conv_end) begin
                     tmr <= tmr - 32'd1;
                  end else if (nch != 2'd3) begin
                     ch  <= nch;
                     tmr <= ch_ct(adc_cfg, nch);
                  end else if (last_rnd) begin
                     st <= PMAM_FIN;
                  end else begin
                     avg_n <= avg_n + 10'd1;
                     ch    <= nxt(en, 3'd0);
                     tmr   <= ch_ct(adc_cfg, nxt(en, 3'd0));
                  end
               end
               PMAM_FIN: begin
                  if (mode == PMAM_M_CONT) begin
                     st  <= PMAM_CONV;
                     ch  <= nxt(en, 3'd0);
                     tmr <= ch_ct(adc_cfg, nxt(en, 3'd0));
                  end else begin
                     st  <= PMAM_SD;
                     tmr <= 32'd1;
                  end
               end
               default: st <= PMAM_SD;
            endcase
         end
      end
   end

   // accumulation and output results
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++) begin
            acc[i] <= '0;
            res[i] <= 16'h0;
         end
      end else if (srst) begin
         for (int i = 0; i < 4; i++) begin
            acc[i] <= '0;
            res[i] <= 16'h0;
         end
      end else if (ce) begin
         if (conv_end) begin
            acc[ch] <= (avg_n == 10'd0) ? 26'(pick(ch)) : acc[ch] + 26'(pick(ch));
            if (ch == 2'd0) begin
               acc[3] <= (avg_n == 10'd0) ? 26'(smp.power) : acc[3] + 26'(smp.power);
            end
         end
         if (st == PMAM_FIN) begin
            for (int i = 0; i < 4; i++) begin
               res[i] <= 16'(acc[i] >>> ash(avgc));
            end
         end
      end
   end

   // limit flags: refreshed per compare, sticky under hold, cleared by status read
   pmam_flags_t raw_f;
   pmam_flags_t raw_m;
   pmam_flags_t avg_f;
   pmam_flags_t avg_m;
   always_comb begin
      raw_f = '0;
      raw_m = '0;
      avg_f = '0;
      avg_m = '0;
      if (conv_end && !averaged_compare_enable) begin
         raw_f = lim(ch, pick(ch));
         raw_m = chm(ch);
         if (ch == 2'd0) begin
            raw_f = raw_f | lim(2'd3, smp.power);
            raw_m = raw_m | chm(2'd3);
         end
      end
      if (st == PMAM_FIN && averaged_compare_enable) begin
         for (int i = 0; i < 4; i++) begin
            if (i == 3 ? en[0] : en[i]) begin
               avg_f = avg_f | lim(2'(i), 16'(acc[i] >>> ash(avgc)));
               avg_m = avg_m | chm(2'(i));
            end
         end
      end
   end

   wire pmam_flags_t new_f = raw_f | avg_f;
   wire pmam_flags_t new_m = raw_m | avg_m;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= '0;
      end else if (srst) begin
         flags <= '0;
      end else if (ce) begin
         if (alert_hold_enable) begin
            flags <= (diag_rd ? '0 : flags) | new_f;
         end else begin
            flags <= ((diag_rd ? '0 : flags) & ~new_m) | new_f;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_done_flag           <= 1'b0;
         arithmetic_overflow_flag <= 1'b0;
      end else if (srst) begin
         conv_done_flag           <= 1'b0;
         arithmetic_overflow_flag <= 1'b0;
      end else if (ce) begin
         if (st == PMAM_FIN) begin
            conv_done_flag <= 1'b1;
         end else if (diag_rd || (mode_wr && nadc[`PMAM_ADC_MODE] != PMAM_M_SD)) begin
            conv_done_flag <= 1'b0;
         end
         if (arith_ovf) begin
            arithmetic_overflow_flag <= 1'b1;
         end else if (diag_rd) begin
            arithmetic_overflow_flag <= 1'b0;
         end
      end
   end

   // trim health arrives from a pin: two-stage synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trim_meta           <= 1'b0;
         trim_memory_ok_flag <= 1'b0;
      end else if (ce) begin
         trim_meta           <= trim_ok_pin;
         trim_memory_ok_flag <= trim_meta;
      end
   end

   // open-drain alert: oe_n low pulls the pin low
   wire alert_act = (|flags) | (conv_done_alert_enable & conv_done_flag);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alert_o    <= 1'b0;
         alert_oe_n <= 1'b1;
      end else if (ce) begin
         alert_o    <= 1'b0;
         alert_oe_n <= alert_polarity_select ? alert_act : ~alert_act;
      end
   end

endmodule

// *** verification/pmam_top_assertions.sv ***
// pmam_top_assertions.sv: bus timing and alert pin checks on the pmam_top ports
// assumes one AHB-Lite master with hready fed from hreadyout
`timescale 1ns/1ps
module pmam_chk #(
   parameter int unsigned CYC_PER_US = 10
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [31:0] hrdata,
   input  wire logic        alert_o,
   input  wire logic        alert_oe_n
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic req;
   assign req = hsel && hready && htrans[1] && ce;
   sequence s_rd(a);
      req && !hwrite && haddr[7:0] == a;
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rd_wait;
      req && !hwrite |=> s_wait;
   endproperty
   property p_wr_zero;
      req && hwrite |=> hreadyout;
   endproperty
   property p_one_wait;
      !hreadyout |=> hreadyout;
   endproperty
   property p_okay;
      hresp == 1'b0;
   endproperty
   property p_od;
      alert_o == 1'b0;
   endproperty
   property p_unmap;
      s_rd(8'h34) |-> ##2 hrdata == 32'h0;
   endproperty
   property p_cfg0;
      s_rd(8'h00) |-> ##2 hrdata[0] == 1'b0;
   endproperty
   property p_upper;
      s_rd(8'h10) |-> ##2 hrdata[31:16] == 16'h0;
   endproperty
   // first edge out of reset still shows the reset levels
   property p_por;
      $rose(hresetn) |-> hreadyout && alert_oe_n;
   endproperty
   a_rd_wait: assert property (p_rd_wait)
      else $error("read wait not one cycle");
   a_wr_zero: assert property (p_wr_zero)
      else $error("write not zero wait");
   a_one_wait: assert property (p_one_wait)
      else $error("wait longer than one cycle");
   a_okay: assert property (p_okay)
      else $error("response not okay");
   a_od: assert property (p_od)
      else $error("alert data not low");
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   a_cfg0: assert property (p_cfg0)
      else $error("soft reset bit reads one");
   a_upper: assert property (p_upper)
      else $error("threshold upper half not zero");
   a_por: assert property (p_por)
      else $error("outputs not at reset levels");
endmodule

bind pmam_top pmam_chk #(.CYC_PER_US(CYC_PER_US)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .alert_o(alert_o), .alert_oe_n(alert_oe_n)
);

// *** verification/pmam_host_model.sv ***
// pmam_host_model: host side of the alert pin, an open-drain line with pull-up
// assumes alert_oe_n low means the device pulls the line to alert_o
`timescale 1ns/1ps
module pmam_host_model (
   input  wire logic alert_o,
   input  wire logic alert_oe_n,
   output logic      alert_pin
);
   // released line reads the pull-up level, never the last driven value
   assign alert_pin = alert_oe_n ? 1'b1 : alert_o;
endmodule

// *** verification/tb_top.sv ***
// tb_top: self-checking bench for pmam_top, one task per scenario
// assumes CYC_PER_US of 1, so one microsecond of conversion is one cycle
`timescale 1ns/1ps
`include "pmam_defines.svh"
module tb_top;
   import pmam_pkg::*;
   logic         hclk = 1'b0;
   logic         hresetn = 1'b0;
   logic [31:0]  haddr = '0;
   logic [1:0]   htrans = '0;
   logic         hwrite = 1'b0;
   logic [31:0]  hwdata = '0;
   logic         hready;
   logic         hreadyout;
   logic         hresp;
   logic [31:0]  hrdata;
   pmam_sample_t smp = '0;
   logic         arith_ovf = 1'b0;
   logic         alert_o;
   logic         alert_oe_n;
   logic         pin;
   logic [31:0]  q;
   int           errors = 0;
   int           n_checks = 0;
   int           cyc = 0;
   int           n;

   always #50 hclk = ~hclk;
   assign hready = hreadyout;

   pmam_top #(.CYC_PER_US(1)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .smp(smp), .arith_ovf(arith_ovf), .trim_ok_pin(1'b1),
      .alert_o(alert_o), .alert_oe_n(alert_oe_n)
   );
   pmam_host_model u_host (.alert_o(alert_o), .alert_oe_n(alert_oe_n), .alert_pin(pin));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // address phase held until hready, then data phase held until hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string s);
      bus(1'b0, a, 32'h0);
      chk(q & m, e, s);
   endtask

   task automatic wait_pin(input logic l, input int lim);
      n = 0;
      while (pin !== l && n < lim) begin
         @(posedge hclk);
         n++;
      end
   endtask

   task automatic t_reset;
      logic [15:0] def [6] = '{`PMAM_THR_SUL, `PMAM_THR_SOL, `PMAM_THR_BOL,
                               `PMAM_THR_BUL, `PMAM_THR_TMP, `PMAM_THR_PWR};
      for (int i = 0; i < 6; i++)
         rdc(`PMAM_A_THR0 + 8'(4 * i), '1, {16'h0, def[i]}, "thr default");
      rdc(`PMAM_A_ADC, '1, {15'h0, `PMAM_ADC_RST}, "cfg default");
      wr(`PMAM_A_ADC, 32'h0);
      rdc(`PMAM_A_DIAG, 32'hf002, 32'h2, "status default");
      wr(8'h34, 32'h1);
      rdc(8'h34, '1, 32'h0, "unmapped");
      wr(8'h1c, 32'h55aa);
      rdc(8'h1c, '1, 32'h55aa, "write in shutdown");
      $display("done: reset");
   endtask

   task automatic t_over;
      wr(8'h10, 32'h0100);
      smp.shunt <= 16'sh0100;
      wr(`PMAM_A_ADC, 32'h5);
      repeat (80) @(posedge hclk);
      rdc(`PMAM_A_DIAG, 32'h184, 32'h4, "equal gives no flag");
      chk(pin, 1, "done alone no alert");
      smp.shunt <= 16'sh0101;
      wr(`PMAM_A_ADC, 32'h5);
      wait_pin(1'b0, 80);
      chk(pin, 0, "over alert");
      rdc(`PMAM_A_DIAG, 32'h184, 32'h104, "over and done");
      repeat (3) @(posedge hclk);
      chk(pin, 1, "read releases");
      repeat (100) @(posedge hclk);
      rdc(`PMAM_A_DIAG, 32'h104, 32'h0, "stays shut down");
      $display("done: over");
   endtask

   task automatic t_hold;
      wr(`PMAM_A_DIAG, 32'h8000);
      wr(`PMAM_A_THR0, 32'hff00);
      smp.shunt <= 16'shfe00;
      wr(`PMAM_A_ADC, 32'h5);
      wait_pin(1'b0, 80);
      smp.shunt <= 16'sh0;
      wr(`PMAM_A_ADC, 32'h5);
      repeat (80) @(posedge hclk);
      chk(pin, 0, "held after clear");
      rdc(`PMAM_A_DIAG, 32'h8084, 32'h8084, "under flag held");
      repeat (3) @(posedge hclk);
      chk(pin, 1, "held alert released");
      wr(`PMAM_A_DIAG, 32'h0);
      $display("done: hold");
   endtask

   task automatic t_pol;
      wr(`PMAM_A_DIAG, 32'h5000);
      repeat (3) @(posedge hclk);
      chk(pin, 0, "inverted idle level");
      arith_ovf <= 1'b1;
      @(posedge hclk);
      arith_ovf <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(pin, 0, "overflow no alert");
      wr(`PMAM_A_ADC, 32'h5);
      wait_pin(1'b1, 80);
      chk(pin, 1, "done alert");
      rdc(`PMAM_A_DIAG, 32'h5005, 32'h5005, "overflow and done");
      repeat (3) @(posedge hclk);
      chk(pin, 0, "done alert released");
      wr(`PMAM_A_DIAG, 32'h0);
      $display("done: polarity");
   endtask

   // avg 4 at 50 us: raw compare would alert near 50, averaged near 200
   task automatic t_slow;
      smp.shunt <= 16'sh0200;
      wr(`PMAM_A_DIAG, 32'h2000);
      wr(`PMAM_A_ADC, 32'h4005);
      wait_pin(1'b0, 300);
      chk(n >= 195 && n <= 210, 1, "averaged compare delay");
      rdc(`PMAM_A_DIAG, 32'h2100, 32'h2100, "averaged over flag");
      wr(`PMAM_A_DIAG, 32'h0);
      smp.shunt <= 16'sh0;
      $display("done: slow");
   endtask

   // shunt 84 us and bus 50 us, 4 rounds: 536 cycles
   task automatic t_avg;
      wr(`PMAM_A_DIAG, 32'h4000);
      wr(`PMAM_A_ADC, 32'h402d);
      wait_pin(1'b0, 700);
      chk(n >= 534 && n <= 542, 1, "averaged done time");
      bus(1'b0, `PMAM_A_DIAG, 32'h0);
      $display("done: avg");
   endtask

   task automatic t_abort;
      wr(`PMAM_A_ADC, 32'h8005);
      repeat (300) @(posedge hclk);
      wr(`PMAM_A_ADC, 32'h5);
      wait_pin(1'b0, 100);
      chk(n <= 60, 1, "restart on mode write");
      wr(`PMAM_A_ADC, 32'h5);
      rdc(`PMAM_A_DIAG, 32'h4, 32'h0, "mode write clears done");
      wait_pin(1'b0, 100);
      wr(`PMAM_A_ADC, 32'h4);
      rdc(`PMAM_A_DIAG, 32'h4, 32'h4, "shutdown write keeps done");
      wr(`PMAM_A_DIAG, 32'h0);
      $display("done: abort");
   endtask

   task automatic t_srst;
      wr(8'h10, 32'h1234);
      wr(8'h00, 32'h1);
      rdc(8'h00, 32'h1, 32'h0, "reset bit reads 0");
      rdc(8'h10, '1, 32'h7fff, "soft reset thr");
      rdc(`PMAM_A_ADC, '1, {15'h0, `PMAM_ADC_RST}, "soft reset cfg");
      wr(`PMAM_A_ADC, 32'h0);
      $display("done: soft reset");
   endtask

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         print_verdict;
      end
   end

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_over;
      t_hold;
      t_pol;
      t_slow;
      t_avg;
      t_abort;
      t_srst;
      print_verdict;
   end
endmodule
